// file: src/acd_pkg.sv
// Package of constants and types shared by the accumulator datapath files.
package acd_pkg;
  localparam int          INSTR_W     = 12;
  localparam int          DATA_W      = 8;
  localparam int          FILE_AW     = 7;
  localparam int          PC_W_MAX    = 11;
  localparam int          STACK_DEPTH = 2;
  localparam logic [11:0] INSTR_NOP   = 12'h000;

  // Low five bits of the special function registers held inside the core.
  localparam logic [4:0] SFR_INDF   = 5'h00;
  localparam logic [4:0] SFR_PCL    = 5'h02;
  localparam logic [4:0] SFR_STATUS = 5'h03;
  localparam logic [4:0] SFR_FSR    = 5'h04;

  // Status register layout and reset values.
  localparam int         ST_C           = 0;
  localparam int         ST_DC          = 1;
  localparam int         ST_Z           = 2;
  localparam int         ST_PA_LO       = 5;
  localparam int         ST_PA_HI       = 6;
  localparam logic [7:0] STATUS_RO_MASK = 8'h18;
  localparam logic [7:0] STATUS_RESET   = 8'h18;
  localparam logic [7:0] FSR_RESET      = 8'h00;
  localparam logic [7:0] W_RESET        = 8'h00;

  // Instruction groups on bits 11:10, bit operations on bits 9:8.
  localparam logic [1:0] GRP_BYTE  = 2'h0;
  localparam logic [1:0] GRP_BIT   = 2'h1;
  localparam logic [1:0] BIT_CLR   = 2'h0;
  localparam logic [1:0] BIT_SET   = 2'h1;
  localparam logic [1:0] BIT_TSTC  = 2'h2;
  localparam logic [1:0] BIT_TSTS  = 2'h3;
  localparam logic [2:0] MISC_OPT  = 3'h2;
  localparam logic [2:0] MISC_SLP  = 3'h3;
  localparam logic [2:0] MISC_WDT  = 3'h4;
  localparam logic [2:0] MISC_TRIS = 3'h5;
  localparam logic [3:0] LOP_RET   = 4'h8;
  localparam logic [3:0] LOP_CALL  = 4'h9;
  localparam logic [3:0] LOP_GOTO0 = 4'hA;
  localparam logic [3:0] LOP_GOTO1 = 4'hB;
  localparam logic [3:0] LOP_MOV   = 4'hC;
  localparam logic [3:0] LOP_IOR   = 4'hD;
  localparam logic [3:0] LOP_AND   = 4'hE;
  localparam logic [3:0] LOP_XOR   = 4'hF;

  // Byte-oriented file operations on bits 9:6.
  typedef enum logic [3:0] {
    FOP_MISC = 4'h0, FOP_CLR = 4'h1, FOP_SUB = 4'h2, FOP_DEC = 4'h3,
    FOP_IOR = 4'h4, FOP_AND = 4'h5, FOP_XOR = 4'h6, FOP_ADD = 4'h7,
    FOP_MOV = 4'h8, FOP_COM = 4'h9, FOP_INC = 4'hA, FOP_DECSZ = 4'hB,
    FOP_RR = 4'hC, FOP_RL = 4'hD, FOP_SWAP = 4'hE, FOP_INCSZ = 4'hF
  } acd_fop_type;

  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0, ALU_PASS_B = 4'h1, ALU_ADD = 4'h2, ALU_SUB = 4'h3,
    ALU_AND = 4'h4, ALU_IOR = 4'h5, ALU_XOR = 4'h6, ALU_COM = 4'h7,
    ALU_INC = 4'h8, ALU_DEC = 4'h9, ALU_RR = 4'hA, ALU_RL = 4'hB,
    ALU_SWAP = 4'hC
  } acd_alu_op_type;
endpackage

// file: src/acd_alu_if.sv
// Interface joining the core sequencer to its 8-bit ALU.
`timescale 1ns/100ps
interface acd_alu_if;
  acd_pkg::acd_alu_op_type op;
  logic [7:0]              a;
  logic [7:0]              b;
  logic                    cin;
  logic [7:0]              res;
  logic                    cout;
  logic                    dcout;
  logic                    zero;
  modport core (output op, a, b, cin, input res, cout, dcout, zero);
  modport alu (input op, a, b, cin, output res, cout, dcout, zero);
endinterface

// file: src/acd_alu.sv
// Combinational 8-bit ALU with carry, nibble carry and zero outputs.
`timescale 1ns/100ps
module acd_alu (
  acd_alu_if.alu bus
);
  logic       sub;
  logic [7:0] a_eff;
  logic [8:0] sum;
  logic [4:0] nib;

  // Subtraction adds the complement plus one, so carry out means no borrow.
  assign sub   = (bus.op == acd_pkg::ALU_SUB);
  assign a_eff = sub ? ~bus.a : bus.a;
  assign sum   = {1'b0, bus.b} + {1'b0, a_eff} + {8'h00, sub};
  assign nib   = {1'b0, bus.b[3:0]} + {1'b0, a_eff[3:0]} + {4'h0, sub};

  // Result and carry selection.
  always_comb begin
    bus.cout = bus.cin;
    unique case (bus.op)
      acd_pkg::ALU_PASS_A: bus.res = bus.a;
      acd_pkg::ALU_PASS_B: bus.res = bus.b;
      acd_pkg::ALU_ADD,
      acd_pkg::ALU_SUB: begin
        bus.res  = sum[7:0];
        bus.cout = sum[8];
      end
      acd_pkg::ALU_AND:    bus.res = bus.a & bus.b;
      acd_pkg::ALU_IOR:    bus.res = bus.a | bus.b;
      acd_pkg::ALU_XOR:    bus.res = bus.a ^ bus.b;
      acd_pkg::ALU_COM:    bus.res = ~bus.b;
      acd_pkg::ALU_INC:    bus.res = bus.b + 8'h01;
      acd_pkg::ALU_DEC:    bus.res = bus.b - 8'h01;
      acd_pkg::ALU_RR: begin
        bus.res  = {bus.cin, bus.b[7:1]};
        bus.cout = bus.b[0];
      end
      acd_pkg::ALU_RL: begin
        bus.res  = {bus.b[6:0], bus.cin};
        bus.cout = bus.b[7];
      end
      default:             bus.res = {bus.b[3:0], bus.b[7:4]};
    endcase
  end

  assign bus.dcout = nib[4];
  assign bus.zero  = (bus.res == 8'h00);
endmodule // acd_alu

// file: src/acd_stack.sv
// Return address stack that overwrites its oldest entry on overflow.
`timescale 1ns/100ps
module acd_stack #(
  parameter int W     = 11,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] level [DEPTH];

  if (DEPTH < 2) begin : g_chk
    $error("acd_stack needs at least two levels");
  end

  // Push shifts down, pop shifts up and leaves the bottom entry duplicated.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) level[i] <= '0;
    end else if (push) begin
      level[0] <= din;
      for (int i = 1; i < DEPTH; i++) level[i] <= level[i-1];
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) level[i] <= level[i+1];
    end
  end

  assign dout = level[0];

  a_stack_return: assert property (@(posedge clk_sys) disable iff (!nrst)
    push |=> dout == $past(din)) else $error("stack top differs from pushed value");
endmodule // acd_stack

// file: src/acd_core.sv
// Two-stage accumulator core: fetch, decode, file access and flag update.
`timescale 1ns/100ps
module acd_core #(
  parameter int PC_W = 11
) (
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic [11:0]     prog_data,
  input  wire logic [7:0]      file_rdata,
  output logic      [PC_W-1:0] prog_addr,
  output logic      [6:0]      file_raddr,
  output logic      [6:0]      file_waddr,
  output logic      [7:0]      file_wdata,
  output logic                 file_we,
  output logic                 option_load,
  output logic                 tris_load,
  output logic      [1:0]      tris_sel,
  output logic                 sleep_req,
  output logic                 wdt_clear
);
  if (!(PC_W inside {9, 10, 11})) begin : g_chk
    $error("program counter width must be 9, 10 or 11");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline state: ir holds the word under execution, prog_addr the fetch.
  logic [11:0] ir;
  logic [7:0]  w;
  logic [7:0]  status;
  logic [7:0]  fsr;
  logic [7:0]  next_status;
  logic [7:0]  next_fsr;
  logic [PC_W-1:0] ret_addr;
  acd_alu_if alu_bus ();

  // Decode outputs; the operation is a plain vector so that it can share a concatenation.
  logic [3:0] op;
  logic a_bit;
  logic b_lit;
  logic b_zero;
  logic wr_w;
  logic wr_f;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic skz;
  logic sk_clr;
  logic sk_set;
  logic jmp_goto;
  logic jmp_call;
  logic jmp_ret;
  logic p_opt;
  logic p_tris;
  logic p_slp;
  logic p_wdt;

  acd_alu u_alu (.bus(alu_bus));

  acd_stack #(.W(PC_W), .DEPTH(acd_pkg::STACK_DEPTH)) u_stack (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .push    (jmp_call),
    .pop     (jmp_ret),
    .din     (prog_addr),
    .dout    (ret_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode; every word is one complete instruction.
  always_comb begin
    op = acd_pkg::ALU_PASS_B;
    {a_bit, b_lit, b_zero, wr_w, wr_f, upd_c, upd_dc, upd_z} = 8'h00;
    {skz, sk_clr, sk_set, jmp_goto, jmp_call, jmp_ret} = 6'h00;
    {p_opt, p_tris, p_slp, p_wdt} = 4'h0;
    if (ir[11:10] == acd_pkg::GRP_BYTE) begin
      wr_f = ir[5];
      wr_w = ~ir[5];
      unique case (acd_pkg::acd_fop_type'(ir[9:6]))
        acd_pkg::FOP_MISC: begin
          wr_w = 1'b0;
          op   = acd_pkg::ALU_PASS_A;
          if (!ir[5]) begin
            p_opt  = (ir[2:0] == acd_pkg::MISC_OPT);
            p_slp  = (ir[2:0] == acd_pkg::MISC_SLP);
            p_wdt  = (ir[2:0] == acd_pkg::MISC_WDT);
            p_tris = (ir[2:0] >= acd_pkg::MISC_TRIS);
          end
        end
        acd_pkg::FOP_CLR:   {b_zero, upd_z} = 2'b11;
        acd_pkg::FOP_SUB:   {op, upd_c, upd_dc, upd_z} = {acd_pkg::ALU_SUB, 3'b111};
        acd_pkg::FOP_DEC:   {op, upd_z} = {acd_pkg::ALU_DEC, 1'b1};
        acd_pkg::FOP_IOR:   {op, upd_z} = {acd_pkg::ALU_IOR, 1'b1};
        acd_pkg::FOP_AND:   {op, upd_z} = {acd_pkg::ALU_AND, 1'b1};
        acd_pkg::FOP_XOR:   {op, upd_z} = {acd_pkg::ALU_XOR, 1'b1};
        acd_pkg::FOP_ADD:   {op, upd_c, upd_dc, upd_z} = {acd_pkg::ALU_ADD, 3'b111};
        acd_pkg::FOP_MOV:   upd_z = 1'b1;
        acd_pkg::FOP_COM:   {op, upd_z} = {acd_pkg::ALU_COM, 1'b1};
        acd_pkg::FOP_INC:   {op, upd_z} = {acd_pkg::ALU_INC, 1'b1};
        acd_pkg::FOP_DECSZ: {op, skz} = {acd_pkg::ALU_DEC, 1'b1};
        acd_pkg::FOP_RR:    {op, upd_c} = {acd_pkg::ALU_RR, 1'b1};
        acd_pkg::FOP_RL:    {op, upd_c} = {acd_pkg::ALU_RL, 1'b1};
        acd_pkg::FOP_SWAP:  op = acd_pkg::ALU_SWAP;
        acd_pkg::FOP_INCSZ: {op, skz} = {acd_pkg::ALU_INC, 1'b1};
      endcase
    end else if (ir[11:10] == acd_pkg::GRP_BIT) begin
      a_bit = 1'b1;
      unique case (ir[9:8])
        acd_pkg::BIT_CLR:  {op, wr_f} = {acd_pkg::ALU_AND, 1'b1};
        acd_pkg::BIT_SET:  {op, wr_f} = {acd_pkg::ALU_IOR, 1'b1};
        acd_pkg::BIT_TSTC: sk_clr = 1'b1;
        acd_pkg::BIT_TSTS: sk_set = 1'b1;
      endcase
    end else begin
      b_lit = 1'b1;
      unique case (ir[11:8])
        acd_pkg::LOP_RET:   {jmp_ret, wr_w} = 2'b11;
        acd_pkg::LOP_CALL:  jmp_call = 1'b1;
        acd_pkg::LOP_GOTO0,
        acd_pkg::LOP_GOTO1: jmp_goto = 1'b1;
        acd_pkg::LOP_MOV:   wr_w = 1'b1;
        acd_pkg::LOP_IOR:   {op, wr_w, upd_z} = {acd_pkg::ALU_IOR, 2'b11};
        acd_pkg::LOP_AND:   {op, wr_w, upd_z} = {acd_pkg::ALU_AND, 2'b11};
        default:            {op, wr_w, upd_z} = {acd_pkg::ALU_XOR, 2'b11};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection: core-held special registers answer before the file.
  logic [7:0]  bit_mask;
  logic [4:0]  ex_lo;
  logic        sfr_page;
  logic        fwd;
  logic [7:0]  fdat;
  logic        hit_pcl;
  logic        hit_status;
  logic        hit_fsr;
  logic        hit_indf;
  logic        bit_val;
  logic        skip;
  logic        branch;
  logic        wr_pcl;

  assign bit_mask   = 8'h01 << ir[7:5];
  assign ex_lo      = file_raddr[4:0];
  assign sfr_page   = 1'b1;
  assign hit_indf   = (ex_lo == acd_pkg::SFR_INDF);
  assign hit_pcl    = (ex_lo == acd_pkg::SFR_PCL);
  assign hit_status = (ex_lo == acd_pkg::SFR_STATUS);
  assign hit_fsr    = (ex_lo == acd_pkg::SFR_FSR);
  assign fwd        = file_we && (file_waddr == file_raddr);
  assign fdat       = hit_indf   ? 8'h00 :
                      hit_pcl    ? 8'(prog_addr) :
                      hit_status ? status :
                      hit_fsr    ? fsr :
                      fwd        ? file_wdata : file_rdata;

  // Accumulator or bit mask on side a, file, literal or zero on side b.
  assign alu_bus.op  = acd_pkg::acd_alu_op_type'(op);
  assign alu_bus.a   = a_bit ? (ir[8] ? bit_mask : ~bit_mask) : w;
  assign alu_bus.b   = b_zero ? 8'h00 : (b_lit ? ir[7:0] : fdat);
  assign alu_bus.cin = status[acd_pkg::ST_C];

  // Skips and jumps both discard the word fetched beside them.
  assign bit_val = |(fdat & bit_mask);
  assign skip    = (skz & alu_bus.zero) | (sk_clr & ~bit_val) | (sk_set & bit_val);
  assign wr_pcl  = wr_f && hit_pcl && sfr_page;
  assign branch  = jmp_goto | jmp_call | jmp_ret | wr_pcl;

  ////////////////////////////////////////////////////////////////////////////
  // Next status and FSR; flag updates override a direct status write.
  always_comb begin
    next_status = status;
    if (wr_f && hit_status) begin
      next_status = (alu_bus.res & ~acd_pkg::STATUS_RO_MASK) |
                    (status & acd_pkg::STATUS_RO_MASK);
    end
    if (upd_c)  next_status[acd_pkg::ST_C]  = alu_bus.cout;
    if (upd_dc) next_status[acd_pkg::ST_DC] = alu_bus.dcout;
    if (upd_z)  next_status[acd_pkg::ST_Z]  = alu_bus.zero;
  end

  assign next_fsr = (wr_f && hit_fsr) ? alu_bus.res : fsr;

  // Address for the word being fetched, formed from the FSR it will see.
  logic [6:0]  next_raddr;
  logic [1:0]  pa;
  logic [10:0] target;

  assign next_raddr = (prog_data[4:0] == acd_pkg::SFR_INDF) ? next_fsr[6:0] :
                      {next_fsr[6:5], prog_data[4:0]};
  assign pa         = status[acd_pkg::ST_PA_HI:acd_pkg::ST_PA_LO];
  assign target     = jmp_ret  ? 11'(ret_addr) :
                      jmp_goto ? {pa, ir[8:0]} :
                      jmp_call ? {pa, 1'b0, ir[7:0]} : {pa, 1'b0, alu_bus.res};

  ////////////////////////////////////////////////////////////////////////////
  // Fetch stage: a new word every cycle, a NOP in place of a discarded one.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prog_addr <= '1;
      ir        <= acd_pkg::INSTR_NOP;
    end else begin
      prog_addr <= branch ? target[PC_W-1:0] : prog_addr + PC_W'(1);
      ir        <= (branch | skip) ? acd_pkg::INSTR_NOP : prog_data;
    end
  end

  // Execute stage: the accumulator has no file address and is written here.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      w      <= acd_pkg::W_RESET;
      status <= acd_pkg::STATUS_RESET;
      fsr    <= acd_pkg::FSR_RESET;
    end else begin
      if (wr_w) w <= alu_bus.res;
      status <= next_status;
      fsr    <= next_fsr;
    end
  end

  // File write port, registered; control strobes carry the accumulator.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      file_raddr  <= 7'h00;
      file_waddr  <= 7'h00;
      file_wdata  <= 8'h00;
      file_we     <= 1'b0;
      {option_load, tris_load, sleep_req, wdt_clear} <= 4'h0;
      tris_sel    <= 2'h0;
    end else begin
      file_raddr  <= next_raddr;
      file_waddr  <= file_raddr;
      file_wdata  <= (p_opt | p_tris) ? w : alu_bus.res;
      file_we     <= wr_f && !(hit_indf | hit_pcl | hit_status | hit_fsr);
      {option_load, tris_load, sleep_req, wdt_clear} <= {p_opt, p_tris, p_slp, p_wdt};
      tris_sel    <= ir[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pipeline and on the datapath results.
  sequence s_branch;
    branch;
  endsequence
  sequence s_flushed;
    ##1 (ir == acd_pkg::INSTR_NOP);
  endsequence

  a_branch_flush: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_branch |-> s_flushed) else $error("fetched word kept after a branch");
  a_fetch_step: assert property (@(posedge clk_sys) disable iff (!nrst)
    !branch |=> prog_addr == $past(prog_addr) + PC_W'(1)) else $error("fetch did not advance");
  a_ir_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(branch | skip) |=> ir == $past(prog_data)) else $error("fetched word not taken");
  a_acc_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !wr_w |=> $stable(w)) else $error("accumulator changed without a write");
  a_sub_borrow: assert property (@(posedge clk_sys) disable iff (!nrst)
    (op == acd_pkg::ALU_SUB) && upd_c |=>
      status[acd_pkg::ST_C] == ($past(alu_bus.b) >= $past(alu_bus.a)))
    else $error("borrow flag wrong after subtract");
  a_nibble_add: assert property (@(posedge clk_sys) disable iff (!nrst)
    (op == acd_pkg::ALU_ADD) |->
      alu_bus.dcout == ((5'(alu_bus.a[3:0]) + 5'(alu_bus.b[3:0])) > 5'h0F))
    else $error("nibble carry wrong after add");
  a_zero_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
    upd_z |=> status[acd_pkg::ST_Z] == ($past(alu_bus.res) == 8'h00))
    else $error("zero flag does not follow result");
  a_indirect_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (prog_data[4:0] == acd_pkg::SFR_INDF) |=> file_raddr == $past(next_fsr[6:0]))
    else $error("indirect address not taken from FSR");
  a_file_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_f && !(hit_indf | hit_pcl | hit_status | hit_fsr) |=>
      file_we && file_wdata == $past(alu_bus.res))
    else $error("file result not written");
endmodule // acd_core

// file: test/acd_mem_model.sv
// Behavioural program memory and data register file facing the core.
`timescale 1ns/100ps
module acd_mem_model #(
  parameter int PC_W = 9
) (
  input  wire logic            clk_sys,
  input  wire logic [PC_W-1:0] prog_addr,
  input  wire logic [6:0]      file_raddr,
  input  wire logic [6:0]      file_waddr,
  input  wire logic [7:0]      file_wdata,
  input  wire logic            file_we,
  output logic      [11:0]     prog_data,
  output logic      [7:0]      file_rdata
);
  logic [11:0] mem  [0:(1<<PC_W)-1];
  logic [7:0]  regs [0:127];

  // A whole word comes back in the cycle of its address, from a space of 2**PC_W words.
  assign prog_data  = mem[prog_addr];
  assign file_rdata = regs[file_raddr];

  // Writes land only on the edge, so a late write cannot hide missing forwarding.
  always @(posedge clk_sys) begin
    if (file_we === 1'b1) begin
      regs[file_waddr] <= file_wdata;
    end
  end
endmodule // acd_mem_model

// file: test/testbench.sv
// Self-checking testbench for the accumulator core with its memory model.
`timescale 1ns/100ps
module testbench;
  localparam int PC_W = 9;
  logic            clk_sys;
  logic            nrst;
  logic [11:0]     prog_data;
  logic [7:0]      file_rdata;
  logic [PC_W-1:0] prog_addr;
  logic [6:0]      file_raddr;
  logic [6:0]      file_waddr;
  logic [7:0]      file_wdata;
  logic            file_we;
  logic            option_load;
  logic            tris_load;
  logic [1:0]      tris_sel;
  logic            sleep_req;
  logic            wdt_clear;
  logic [11:0]     prog_q [$];
  logic [19:0]     exp_q  [$];
  logic [19:0]     ev_q   [$];
  logic [PC_W-1:0] pa_q   [$];
  int              miscompares;
  int              cmp_count;

  ////////////////////////////////////////
  acd_core #(.PC_W(PC_W)) dut (.clk_sys(clk_sys), .nrst(nrst), .prog_data(prog_data),
    .file_rdata(file_rdata), .prog_addr(prog_addr), .file_raddr(file_raddr),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .file_we(file_we),
    .option_load(option_load), .tris_load(tris_load), .tris_sel(tris_sel),
    .sleep_req(sleep_req), .wdt_clear(wdt_clear));
  acd_mem_model #(.PC_W(PC_W)) mem (.clk_sys(clk_sys), .prog_addr(prog_addr),
    .file_raddr(file_raddr), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .file_we(file_we), .prog_data(prog_data), .file_rdata(file_rdata));

  // Free-running 50 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Outputs are registered, so the falling edge sees them settled.
  always @(negedge clk_sys) begin
    if (nrst === 1'b1) begin
      pa_q.push_back(prog_addr);
      if (file_we === 1'b1) ev_q.push_back({4'h0, 1'b0, file_waddr, file_wdata});
      if (option_load === 1'b1) ev_q.push_back({4'h1, 8'h00, file_wdata});
      if (tris_load === 1'b1) ev_q.push_back({4'h2, 6'h00, tris_sel, file_wdata});
      if (wdt_clear === 1'b1) ev_q.push_back({4'h3, 16'h0000});
      if (sleep_req === 1'b1) ev_q.push_back({4'h4, 16'h0000});
    end
  end

  ////////////////////////////////////////
  function automatic logic [19:0] wr(logic [6:0] a, logic [7:0] d);
    return {4'h0, 1'b0, a, d};
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_ev(string name, logic [19:0] e, logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_pa(string name, logic [PC_W-1:0] e, logic [PC_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  // Loads the program, resets mid-run and checks the fetch address and write strobe held in reset.
  task automatic start();
    nrst <= 1'b0;
    for (int i = 0; i < (1 << PC_W); i++) mem.mem[i] = acd_pkg::INSTR_NOP;
    foreach (prog_q[i]) mem.mem[i] = prog_q[i];
    for (int i = 0; i < 128; i++) mem.regs[i] = 8'h00;
    repeat (3) @(negedge clk_sys);
    chk_pa("reset fetch address", 9'h1FF, prog_addr);
    chk_ev("reset write strobe", 20'h0, {19'h0, file_we});
    ev_q.delete();
    pa_q.delete();
    nrst <= 1'b1;
  endtask

  // A bounded wait for the expected events, then a quiet spell to catch extra ones.
  task automatic finish_check();
    int n;
    n = 0;
    while (ev_q.size() < exp_q.size()) begin
      @(negedge clk_sys);
      n++;
      if (n > 80) begin
        miscompares++;
        $display("CHECK FAILED event wait expected %0d seen %0d", exp_q.size(), ev_q.size());
        break;
      end
    end
    repeat (8) @(negedge clk_sys);
    chk_ev("event count", 20'(exp_q.size()), 20'(ev_q.size()));
    foreach (exp_q[i]) begin
      if (i < ev_q.size()) chk_ev("event", exp_q[i], ev_q[i]);
    end
  endtask

  ////////////////////////////////////////
  // One fetch per cycle from address zero after the reset vector.
  task automatic s_fetch();
    prog_q = '{};
    exp_q = '{};
    start();
    finish_check();
    for (int i = 0; i < 4; i++) chk_pa("fetch address", PC_W'(i), pa_q[i]);
  endtask

  // Addition with nibble carry, then a wrap to zero with byte carry.
  task automatic s_add();
    prog_q = '{12'hC08, 12'h030, 12'hC08, 12'h1F0, 12'h203, 12'h031,
               12'hCF0, 12'h1D0, 12'h203, 12'h031};
    exp_q = '{wr(7'h10, 8'h08), wr(7'h10, 8'h10), wr(7'h11, 8'h1A), wr(7'h11, 8'h1D)};
    start();
    finish_check();
  endtask

  // Subtraction with borrow out of both halves, then an exact zero.
  task automatic s_sub();
    prog_q = '{12'hC01, 12'h030, 12'hC02, 12'h0B0, 12'h203, 12'h031,
               12'hCFF, 12'h0B0, 12'h203, 12'h031};
    exp_q = '{wr(7'h10, 8'h01), wr(7'h10, 8'hFF), wr(7'h11, 8'h18),
              wr(7'h10, 8'h00), wr(7'h11, 8'h1F)};
    start();
    finish_check();
  endtask

  // Program counter read as a file, pointer write kept inside, indirect store.
  task automatic s_indirect();
    prog_q = '{12'h202, 12'h030, 12'hC12, 12'h024, 12'hC5A, 12'h020,
               12'h272, 12'h204, 12'h031};
    exp_q = '{wr(7'h10, 8'h01), wr(7'h12, 8'h5A), wr(7'h12, 8'hA5), wr(7'h11, 8'h12)};
    start();
    finish_check();
  endtask

  // The word fetched behind a jump must never execute.
  task automatic s_branch();
    logic [PC_W-1:0] pa_e [6];
    pa_e = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h008, 9'h009};
    prog_q = '{12'hC33, 12'h000, 12'hA08, 12'hC77, 12'h000, 12'h000,
               12'h000, 12'h000, 12'h030};
    exp_q = '{wr(7'h10, 8'h33)};
    start();
    finish_check();
    foreach (pa_e[i]) chk_pa("branch fetch", pa_e[i], pa_q[i]);
  endtask

  // Call and literal return, bit set, rotate through carry and a taken bit-test skip.
  task automatic s_flow();
    prog_q = '{12'hC05, 12'h030, 12'h910, 12'h031, 12'h5F0, 12'h370, 12'h730,
               12'h030, 12'h203, 12'h031, 12'hA0A, 12'h000, 12'h000, 12'h000,
               12'h000, 12'h000, 12'h8A7};
    exp_q = '{wr(7'h10, 8'h05), wr(7'h11, 8'hA7), wr(7'h10, 8'h85),
              wr(7'h10, 8'h0A), wr(7'h11, 8'h19)};
    start();
    finish_check();
  endtask

  // Control words carry the accumulator out on their load pulses.
  task automatic s_misc();
    prog_q = '{12'hC3C, 12'h002, 12'h007, 12'h004, 12'h003};
    exp_q = '{20'h1003C, 20'h2033C, 20'h30000, 20'h40000};
    start();
    finish_check();
  endtask

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    nrst = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    @(negedge clk_sys);
    s_fetch();
    s_add();
    s_sub();
    s_indirect();
    s_branch();
    s_misc();
    s_flow();
    results();
  end
endmodule // testbench
